// >>> logic/avfs_defs.svh
// Constants for the AV port frame-sync and keying block
`ifndef AVFS_DEFS_SVH
`define AVFS_DEFS_SVH

`define AVFS_CLK_PERIOD_PS    4000
`define AVFS_FS_PULSE_MIN_PS  100000
`define AVFS_FS_PULSE_CYCLES  ((`AVFS_FS_PULSE_MIN_PS + `AVFS_CLK_PERIOD_PS - 1) / `AVFS_CLK_PERIOD_PS)
`define AVFS_FIFO_DEPTH       8
`define AVFS_BYTE_W           8
`define AVFS_WORD_W           10
`define AVFS_WORD_START_BIT   9
`define AVFS_WORD_KEY_BIT     8
`define AVFS_SYT_W            16
`define AVFS_SYT_CYC_MSB      15
`define AVFS_SYT_CYC_LSB      12
`define AVFS_SYT_OFS_MSB      11
`define AVFS_SYT_NO_INFO      16'hFFFF
`define AVFS_DELAY_W          3
`define AVFS_PULSE_CNT_W      6

`endif

// >>> logic/avfs_fifo.sv
// Synchronous FIFO with a registered output stage
`timescale 1ns/100ps
module avfs_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    avfs_stream_if.snk  wr,
    avfs_stream_if.src  rd
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr_reg;
    logic [PW-1:0]    rptr_reg;
    logic [PW:0]      count_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             push;
    logic             pop;

    // Ready reflects real space, so a stalled reader makes the writer see full
    assign wr.ready = (count_reg != (PW+1)'(DEPTH));
    assign push     = wr.valid && wr.ready;
    assign pop      = (count_reg != '0) && (!out_valid_reg || rd.ready);
    assign rd.valid = out_valid_reg;
    assign rd.data  = out_data_reg;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == PW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == PW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else if (pop) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= mem[rptr_reg];
        end else if (rd.ready) begin
            out_valid_reg <= 1'b0;
        end
    end
endmodule

// >>> logic/avfs_pkg.sv
// Types shared by the AV port frame-sync and keying block
`include "avfs_defs.svh"

package avfs_pkg;
    typedef logic [`AVFS_WORD_W-1:0] avfs_word_t;
    typedef logic [`AVFS_SYT_W-1:0]  avfs_syt_t;
    typedef enum logic [1:0] {
        AVFS_RX_IDLE,
        AVFS_RX_ARMED,
        AVFS_RX_PULSE
    } avfs_rx_state_t;
endpackage

// >>> logic/avfs_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/100ps
interface avfs_stream_if #(parameter int WIDTH = 10);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> logic/avfs_top.sv
// AV port frame-sync time stamping, regeneration and packet keying
`timescale 1ns/100ps
`include "avfs_defs.svh"
module avfs_top
    import avfs_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      av_port_clock,
    input  wire logic [`AVFS_BYTE_W-1:0]   av_tx_data,
    input  wire logic                      av_tx_valid,
    input  wire logic                      av_tx_first,
    input  wire logic                      packet_key_pin,
    input  wire logic                      tx_frame_sync_pin,
    input  wire logic                      tx_frame_sync_enable,
    input  wire logic [`AVFS_DELAY_W-1:0]  tx_syt_delay,
    input  wire logic [`AVFS_SYT_W-1:0]    bus_cycle_time,
    input  wire logic                      pkt_ready,
    input  wire logic                      rx_frame_sync_enable,
    input  wire logic [`AVFS_SYT_W-1:0]    rx_syt,
    input  wire logic                      rx_syt_valid,
    output logic                           av_tx_ready,
    output logic                           tx_overflow,
    output logic                           pkt_valid,
    output logic [`AVFS_BYTE_W-1:0]        pkt_data,
    output logic                           pkt_key,
    output logic                           pkt_start,
    output logic [`AVFS_SYT_W-1:0]         pkt_syt,
    output logic                           rx_frame_sync_pin
);
    avfs_stream_if #(.WIDTH(`AVFS_WORD_W)) fifo_in ();
    avfs_stream_if #(.WIDTH(`AVFS_WORD_W)) fifo_out ();

    logic                     av_clk_reg;
    logic                     av_rise;
    logic [`AVFS_BYTE_W-1:0]  cap_data_reg;
    logic                     cap_valid_reg;
    logic                     cap_first_reg;
    logic                     cap_key_reg;
    logic                     cap_fs_reg;
    logic                     cap_fs_prev_reg;
    logic                     key_hold_reg;
    logic                     in_pkt_reg;
    logic                     drop_reg;
    logic                     word_valid_reg;
    avfs_word_t               word_reg;
    logic                     fs_event;
    logic                     stamp_pend_reg;
    avfs_syt_t                stamp_reg;
    avfs_syt_t                stamp_next;
    logic                     start_taken;
    avfs_rx_state_t           rx_state_reg;
    avfs_syt_t                rx_stamp_reg;
    logic                     match;
    logic                     match_reg;
    logic [`AVFS_PULSE_CNT_W-1:0] pulse_cnt_reg;

    assign av_rise = av_port_clock && !av_clk_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            av_clk_reg <= 1'b0;
        end else begin
            av_clk_reg <= av_port_clock;
        end
    end

    // Only the AV clock's rising edge admits pin values to the port logic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cap_data_reg    <= '0;
            cap_valid_reg   <= 1'b0;
            cap_first_reg   <= 1'b0;
            cap_key_reg     <= 1'b0;
            cap_fs_reg      <= 1'b0;
            cap_fs_prev_reg <= 1'b0;
        end else if (av_rise) begin
            cap_data_reg    <= av_tx_data;
            cap_valid_reg   <= av_tx_valid;
            cap_first_reg   <= av_tx_first;
            cap_key_reg     <= packet_key_pin;
            cap_fs_reg      <= tx_frame_sync_pin;
            cap_fs_prev_reg <= cap_fs_reg;
        end else begin
            cap_valid_reg   <= 1'b0;
            cap_fs_prev_reg <= cap_fs_reg;
        end
    end

    // Key is taken once per packet from the first byte and reused for the rest
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_hold_reg   <= 1'b0;
            in_pkt_reg     <= 1'b0;
            drop_reg       <= 1'b0;
            word_valid_reg <= 1'b0;
            word_reg       <= '0;
            tx_overflow    <= 1'b0;
        end else begin
            word_valid_reg <= 1'b0;
            tx_overflow    <= 1'b0;
            if (cap_valid_reg) begin
                if (cap_first_reg) begin
                    key_hold_reg <= cap_key_reg;
                    in_pkt_reg   <= 1'b1;
                    drop_reg     <= !fifo_in.ready;
                    tx_overflow  <= !fifo_in.ready;
                    word_valid_reg <= fifo_in.ready;
                    word_reg <= {1'b1, cap_key_reg, cap_data_reg};
                end else if (in_pkt_reg && !drop_reg) begin
                    // A byte with no room drops the packet's tail, never a stall
                    drop_reg       <= !fifo_in.ready;
                    tx_overflow    <= !fifo_in.ready;
                    word_valid_reg <= fifo_in.ready;
                    word_reg <= {1'b0, key_hold_reg, cap_data_reg};
                end
            end
        end
    end

    // Capture runs one AV edge apart, so the pushed word lands before ready is rechecked
    assign fifo_in.valid = word_valid_reg;
    assign fifo_in.data  = word_reg;

    avfs_fifo #(
        .WIDTH (`AVFS_WORD_W),
        .DEPTH (`AVFS_FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr       (fifo_in),
        .rd       (fifo_out)
    );

    assign fifo_out.ready = pkt_ready;
    assign pkt_valid = fifo_out.valid;
    assign pkt_data  = fifo_out.data[`AVFS_BYTE_W-1:0];
    assign pkt_key   = fifo_out.data[`AVFS_WORD_KEY_BIT];
    assign pkt_start = fifo_out.data[`AVFS_WORD_START_BIT];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            av_tx_ready <= 1'b0;
        end else begin
            av_tx_ready <= fifo_in.ready;
        end
    end

    assign fs_event    = cap_fs_reg && !cap_fs_prev_reg && tx_frame_sync_enable;
    assign start_taken = pkt_valid && pkt_ready && pkt_start;

    // Stamp is the cycle time advanced by the configured delay in bus cycles
    always_comb begin
        stamp_next = bus_cycle_time;
        stamp_next[`AVFS_SYT_CYC_MSB:`AVFS_SYT_CYC_LSB] =
            bus_cycle_time[`AVFS_SYT_CYC_MSB:`AVFS_SYT_CYC_LSB] + 4'(tx_syt_delay);
    end

    // A newer pulse replaces an unsent stamp; adequate at supported pulse rates
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stamp_pend_reg <= 1'b0;
            stamp_reg      <= `AVFS_SYT_NO_INFO;
        end else if (fs_event) begin
            stamp_pend_reg <= 1'b1;
            stamp_reg      <= stamp_next;
        end else if (start_taken) begin
            stamp_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pkt_syt <= `AVFS_SYT_NO_INFO;
        end else begin
            pkt_syt <= stamp_pend_reg ? stamp_reg : `AVFS_SYT_NO_INFO;
        end
    end

    // Receive regeneration: fire when the cycle timer reaches the stamp
    assign match = (bus_cycle_time[`AVFS_SYT_CYC_MSB:`AVFS_SYT_CYC_LSB]
                    == rx_stamp_reg[`AVFS_SYT_CYC_MSB:`AVFS_SYT_CYC_LSB])
                && (bus_cycle_time[`AVFS_SYT_OFS_MSB:0] >= rx_stamp_reg[`AVFS_SYT_OFS_MSB:0]);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_state_reg      <= AVFS_RX_IDLE;
            rx_stamp_reg      <= `AVFS_SYT_NO_INFO;
            pulse_cnt_reg     <= '0;
            rx_frame_sync_pin <= 1'b0;
        end else begin
            if (rx_syt_valid && rx_frame_sync_enable && rx_syt != `AVFS_SYT_NO_INFO) begin
                rx_stamp_reg <= rx_syt;
            end
            case (rx_state_reg)
                AVFS_RX_IDLE: begin
                    if (rx_syt_valid && rx_frame_sync_enable
                        && rx_syt != `AVFS_SYT_NO_INFO) begin
                        rx_state_reg <= AVFS_RX_ARMED;
                    end
                end
                AVFS_RX_ARMED: begin
                    if (!rx_frame_sync_enable) begin
                        rx_state_reg <= AVFS_RX_IDLE;
                    end else if (match && !match_reg && !rx_syt_valid) begin
                        rx_state_reg      <= AVFS_RX_PULSE;
                        rx_frame_sync_pin <= 1'b1;
                        pulse_cnt_reg     <= `AVFS_PULSE_CNT_W'(`AVFS_FS_PULSE_CYCLES - 1);
                    end
                end
                AVFS_RX_PULSE: begin
                    if (pulse_cnt_reg == '0) begin
                        rx_frame_sync_pin <= 1'b0;
                        rx_state_reg      <= AVFS_RX_IDLE;
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
                    end
                end
                default: begin
                    rx_state_reg      <= AVFS_RX_IDLE;
                    rx_frame_sync_pin <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> test/avfs_codec_model.sv
// Codec model on the byte-wide transmit AV port
`timescale 1ns/100ps
`include "avfs_defs.svh"
module avfs_codec_model (
    input  wire logic                    core_clk,
    output logic                         av_port_clock = 1'b0,
    output logic [`AVFS_BYTE_W-1:0]      av_tx_data = 8'h00,
    output logic                         av_tx_valid = 1'b0,
    output logic                         av_tx_first = 1'b0,
    output logic                         packet_key_pin = 1'b0,
    output logic                         tx_frame_sync_pin = 1'b0
);
    logic [1:0] ph_reg = 2'd0;
    // AV clock runs free at a quarter of the core rate, so rises are 4 cycles apart
    always_ff @(posedge core_clk) begin
        ph_reg        <= ph_reg + 2'd1;
        av_port_clock <= ph_reg[1];
    end
    // Bytes move only on the AV clock's fall, clear of the capturing rise
    task automatic send_pkt(input int n, input logic key, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk iff ph_reg == 2'd0);
            av_tx_valid    <= 1'b1;
            av_tx_first    <= (i == 0);
            av_tx_data     <= base + i[7:0];
            // Later bytes show the opposite key, which must be ignored
            packet_key_pin <= (i == 0) ? key : ~key;
        end
        @(posedge core_clk iff ph_reg == 2'd0);
        av_tx_valid <= 1'b0;
        av_tx_first <= 1'b0;
        av_tx_data  <= ~av_tx_data;
    endtask
    // Isolated 104 ns pulses only, far under the repetition limit
    task automatic fs_pulse();
        @(posedge core_clk iff ph_reg == 2'd0);
        tx_frame_sync_pin <= 1'b1;
        repeat (26) @(posedge core_clk);
        tx_frame_sync_pin <= 1'b0;
    endtask
endmodule

// >>> test/avfs_monitor.sv
// Port-level assertions for the frame-sync and keying block
`timescale 1ns/100ps
`include "avfs_defs.svh"
module avfs_monitor (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     tx_frame_sync_enable,
    input wire logic [`AVFS_DELAY_W-1:0] tx_syt_delay,
    input wire logic [`AVFS_SYT_W-1:0]   bus_cycle_time,
    input wire logic                     pkt_ready,
    input wire logic                     rx_frame_sync_enable,
    input wire logic                     tx_overflow,
    input wire logic                     pkt_valid,
    input wire logic [`AVFS_BYTE_W-1:0]  pkt_data,
    input wire logic                     pkt_key,
    input wire logic                     pkt_start,
    input wire logic [`AVFS_SYT_W-1:0]   pkt_syt,
    input wire logic                     rx_frame_sync_pin
);
    logic key_reg;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Key of the packet whose first word the bus side took
    always_ff @(posedge core_clk) begin
        if (pkt_valid && pkt_ready && pkt_start)
            key_reg <= pkt_key;
    end
    pulse_width_a: assert property ($rose(rx_frame_sync_pin) |-> rx_frame_sync_pin[*8]
        ##1 rx_frame_sync_pin[*8] ##1 rx_frame_sync_pin[*8] ##1 rx_frame_sync_pin
        ##1 !rx_frame_sync_pin) else $error("frame-sync pulse width wrong");
    regen_enable_a: assert property ($rose(rx_frame_sync_pin) |-> $past(rx_frame_sync_enable))
        else $error("frame-sync pulse while regeneration disabled");
    key_const_a: assert property (pkt_valid && !pkt_start |-> pkt_key == key_reg)
        else $error("byte keyed unlike its packet");
    word_hold_a: assert property (pkt_valid && !pkt_ready
        |=> pkt_valid && $stable({pkt_data, pkt_key, pkt_start})) else $error("word not held");
    ovf_pulse_a: assert property (tx_overflow |=> !tx_overflow)
        else $error("overflow longer than one cycle");
    stamp_clear_a: assert property (pkt_valid && pkt_ready && pkt_start
        |-> ##2 pkt_syt == `AVFS_SYT_NO_INFO) else $error("stamp not cleared");
    stamp_value_a: assert property ($changed(pkt_syt) && pkt_syt != `AVFS_SYT_NO_INFO
        |-> pkt_syt == {bus_cycle_time[15:12] + tx_syt_delay, bus_cycle_time[11:0]})
        else $error("stamp value wrong");
    stamp_gate_a: assert property (!tx_frame_sync_enable && pkt_syt == `AVFS_SYT_NO_INFO
        |=> pkt_syt == `AVFS_SYT_NO_INFO) else $error("stamp while disabled");
endmodule

// >>> test/tb.sv
// Self-checking bench for the frame-sync and keying block
`timescale 1ns/100ps
`include "avfs_defs.svh"
module tb;
    logic                      core_clk = 1'b0;
    logic                      rst_n = 1'b0;
    logic                      av_port_clock, av_tx_valid, av_tx_first, packet_key_pin;
    logic [`AVFS_BYTE_W-1:0]   av_tx_data, pkt_data;
    logic                      tx_frame_sync_pin, av_tx_ready, tx_overflow, pkt_valid;
    logic                      pkt_key, pkt_start, rx_frame_sync_pin;
    logic [`AVFS_SYT_W-1:0]    pkt_syt;
    logic                      tx_frame_sync_enable = 1'b0;
    logic [`AVFS_DELAY_W-1:0]  tx_syt_delay = 3'd0;
    logic [`AVFS_SYT_W-1:0]    bus_cycle_time = 16'h0000;
    logic [`AVFS_SYT_W-1:0]    rx_syt = 16'h0000;
    logic                      pkt_ready = 1'b0;
    logic                      rx_frame_sync_enable = 1'b0;
    logic                      rx_syt_valid = 1'b0;
    logic [9:0]                got_q[$];
    logic                      ovf_seen = 1'b0;
    int                        errors = 0;
    int                        n_checks = 0;
    int                        cyc = 0;
    avfs_top avfs_top_inst (
        .core_clk             (core_clk),
        .rst_n                (rst_n),
        .av_port_clock        (av_port_clock),
        .av_tx_data           (av_tx_data),
        .av_tx_valid          (av_tx_valid),
        .av_tx_first          (av_tx_first),
        .packet_key_pin       (packet_key_pin),
        .tx_frame_sync_pin    (tx_frame_sync_pin),
        .tx_frame_sync_enable (tx_frame_sync_enable),
        .tx_syt_delay         (tx_syt_delay),
        .bus_cycle_time       (bus_cycle_time),
        .pkt_ready            (pkt_ready),
        .rx_frame_sync_enable (rx_frame_sync_enable),
        .rx_syt               (rx_syt),
        .rx_syt_valid         (rx_syt_valid),
        .av_tx_ready          (av_tx_ready),
        .tx_overflow          (tx_overflow),
        .pkt_valid            (pkt_valid),
        .pkt_data             (pkt_data),
        .pkt_key              (pkt_key),
        .pkt_start            (pkt_start),
        .pkt_syt              (pkt_syt),
        .rx_frame_sync_pin    (rx_frame_sync_pin)
    );
    avfs_codec_model avfs_codec_model_inst (
        .core_clk          (core_clk),
        .av_port_clock     (av_port_clock),
        .av_tx_data        (av_tx_data),
        .av_tx_valid       (av_tx_valid),
        .av_tx_first       (av_tx_first),
        .packet_key_pin    (packet_key_pin),
        .tx_frame_sync_pin (tx_frame_sync_pin)
    );
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bus side records every word it takes
    always @(posedge core_clk) begin
        if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
            got_q.push_back({pkt_start, pkt_key, pkt_data});
        if (tx_overflow === 1'b1)
            ovf_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic expect_pkt(input int n, input logic key, input logic [7:0] base);
        for (int w = 0; w < 400 && got_q.size() < n; w++) @(posedge core_clk);
        check(16'(got_q.size()), 16'(n));
        for (int i = 0; i < n && i < got_q.size(); i++)
            check(got_q[i], {(i == 0), key, base + i[7:0]});
        got_q.delete();
    endtask
    task automatic t_keys();
        @(posedge core_clk);
        pkt_ready <= 1'b1;
        avfs_codec_model_inst.send_pkt(4, 1'b1, 8'h10);
        expect_pkt(4, 1'b1, 8'h10);
        avfs_codec_model_inst.send_pkt(3, 1'b0, 8'h20);
        expect_pkt(3, 1'b0, 8'h20);
        $display("test keys done");
    endtask
    // Cycle field E plus each delay wraps past 15
    task automatic t_stamp();
        for (int d = 2; d <= 4; d++) begin
            @(posedge core_clk);
            tx_frame_sync_enable <= 1'b1;
            tx_syt_delay         <= d[2:0];
            bus_cycle_time       <= 16'hE123;
            avfs_codec_model_inst.fs_pulse();
            repeat (8) @(posedge core_clk);
            check(pkt_syt, {4'hE + d[3:0], 12'h123});
            avfs_codec_model_inst.send_pkt(2, 1'b0, 8'h30);
            expect_pkt(2, 1'b0, 8'h30);
            check(pkt_syt, `AVFS_SYT_NO_INFO);
        end
        // A pulse with stamping disabled must leave the field empty
        tx_frame_sync_enable <= 1'b0;
        avfs_codec_model_inst.fs_pulse();
        repeat (8) @(posedge core_clk);
        check(pkt_syt, `AVFS_SYT_NO_INFO);
        $display("test stamp done");
    endtask
    task automatic t_over();
        int k;
        @(posedge core_clk);
        pkt_ready <= 1'b0;
        avfs_codec_model_inst.send_pkt(12, 1'b1, 8'h40);
        repeat (8) @(posedge core_clk);
        check(ovf_seen, 1'b1);
        check(av_tx_ready, 1'b0);
        pkt_ready <= 1'b1;
        repeat (100) @(posedge core_clk);
        k = got_q.size();
        check(k >= 8 && k < 12, 1'b1);
        expect_pkt(k, 1'b1, 8'h40);
        check(av_tx_ready, 1'b1);
        avfs_codec_model_inst.send_pkt(3, 1'b0, 8'h50);
        expect_pkt(3, 1'b0, 8'h50);
        $display("test overflow done");
    endtask
    task automatic t_regen(input logic [15:0] syt, input logic en, input int exp_n);
        int n;
        int first;
        n = 0;
        first = 99;
        @(posedge core_clk);
        rx_frame_sync_enable <= en;
        bus_cycle_time       <= 16'h2000;
        rx_syt               <= syt;
        rx_syt_valid         <= 1'b1;
        @(posedge core_clk);
        rx_syt_valid <= 1'b0;
        repeat (10) @(posedge core_clk);
        bus_cycle_time <= 16'h2100;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (rx_frame_sync_pin === 1'b1 && first == 99)
                first = i;
            if (rx_frame_sync_pin === 1'b1)
                n++;
        end
        check(16'(n), 16'(exp_n));
        check(first <= 2 || exp_n == 0, 1'b1);
        rx_frame_sync_enable <= 1'b0;
        $display("test regen done");
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        check(pkt_syt, `AVFS_SYT_NO_INFO);
        check({pkt_valid, rx_frame_sync_pin}, 2'b00);
        @(posedge core_clk);
        rst_n <= 1'b1;
        t_keys();
        t_stamp();
        t_over();
        t_regen(16'h2100, 1'b1, `AVFS_FS_PULSE_CYCLES);
        t_regen(`AVFS_SYT_NO_INFO, 1'b1, 0);
        t_regen(16'h2100, 1'b0, 0);
        finish_test();
    end
endmodule
bind avfs_top avfs_monitor avfs_monitor_inst (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .tx_frame_sync_enable (tx_frame_sync_enable),
    .tx_syt_delay         (tx_syt_delay),
    .bus_cycle_time       (bus_cycle_time),
    .pkt_ready            (pkt_ready),
    .rx_frame_sync_enable (rx_frame_sync_enable),
    .tx_overflow          (tx_overflow),
    .pkt_valid            (pkt_valid),
    .pkt_data             (pkt_data),
    .pkt_key              (pkt_key),
    .pkt_start            (pkt_start),
    .pkt_syt              (pkt_syt),
    .rx_frame_sync_pin    (rx_frame_sync_pin)
);
